/* File: verilog/fifo_level_watermark_control.sv */
// Operation
// - Flush bit resets both buffer pointers
// - After flush count zero, full capacity
// - Size limit selects 255-byte capacity
// - Count tracks writes minus reads
// - Threshold from 03h plus 02h bit2 in full-size mode
// - Almost full when free space <= threshold
// - Almost empty when count <= threshold
// - Write when full sets overflow error
// - Almost-empty rise raises interrupt if enabled
// - Almost-full rise raises interrupt if enabled
// - Small mode fields fit one byte
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module fifo_level_watermark_control
  import buf_pkg::*;
#(
  parameter int depth = full_depth,
  parameter int aw = 9
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire reg_req_type req,
  output logic [7:0] rdata,
  // Internal state machine side
  input wire logic core_wr,
  input wire logic [7:0] core_wdata,
  input wire logic core_rd,
  output logic [7:0] core_rdata,
  output logic core_empty,
  output logic core_full,
  // Interrupt request pin
  output logic irq
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic size_limit_select_r;
  logic level_ext_r;
  logic [7:0] water_level_low_r;
  logic [aw-1:0] wr_ptr_r;
  logic [aw-1:0] rd_ptr_r;
  logic [aw:0] stored_byte_count_r;
  logic overflow_flag_r;
  logic almost_full_int_r;
  logic almost_empty_int_r;
  logic [7:0] int_enable_first_r;
  logic almost_full_d_r;
  logic almost_empty_d_r;
  logic [7:0] rdata_r;

  // Level arithmetic is one bit wider than the pointers so 512 fits
  logic [aw:0] capacity;
  logic [aw:0] alert_threshold;
  logic [aw:0] free_space;
  logic almost_full_flag;
  logic almost_empty_flag;
  logic full;
  logic empty;
  logic flush;
  logic host_wr_data;
  logic host_rd_data;
  logic any_wr;
  logic any_rd;
  logic do_wr;
  logic do_rd;
  logic [7:0] wr_byte;
  logic [7:0] mem_rdata;
  logic [aw-1:0] wr_ptr_nxt;
  logic [aw-1:0] rd_ptr_nxt;
  logic status_wr;
  logic ctrl_wr;
  logic af_rise;
  logic ae_rise;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign flush = req.wr && req.addr == ctrl_off && req.wdata[flush_bit];
  assign host_wr_data = req.wr && req.addr == data_off;
  assign host_rd_data = req.rd && req.addr == data_off;
  // Host port wins when both sides touch the buffer; software must avoid that
  assign any_wr = host_wr_data || core_wr;
  assign any_rd = host_rd_data || core_rd;
  assign wr_byte = host_wr_data ? req.wdata : core_wdata;
  // Control and status writes decoded once for the processes below, so every
  // process agrees on which cycle a write lands
  assign ctrl_wr = req.wr && req.addr == ctrl_off;
  assign status_wr = req.wr && req.addr == int_status_first_off;

  // ---------------------------------------------------------------
  // Levels
  // ---------------------------------------------------------------
  // Capacity per mode
  assign capacity = size_limit_select_r ? (aw+1)'(small_depth) : (aw+1)'(depth);
  // Extension bit is ignored in small mode so the threshold fits a byte
  assign alert_threshold = {{(aw-8){1'b0}}, level_ext_r & ~size_limit_select_r,
                            water_level_low_r};
  // Free space never wraps below zero as long as the size bit is not changed
  // with data stored; software flushes before switching sizes
  assign free_space = capacity - stored_byte_count_r;
  assign almost_full_flag = free_space <= alert_threshold;
  assign almost_empty_flag = stored_byte_count_r <= alert_threshold;
  // Compare with >= so a shrink below the stored count still blocks writes
  assign full = stored_byte_count_r >= capacity;
  assign empty = stored_byte_count_r == '0;
  assign do_wr = any_wr && !full && !flush;
  assign do_rd = any_rd && !empty && !flush;
  assign core_empty = empty;
  assign core_full = full;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  buf_mem #(
    .width(8),
    .depth(depth),
    .aw(aw)
  ) u_mem (
    .mclk(mclk),
    .we(do_wr),
    .waddr(wr_ptr_r),
    .wdata(wr_byte),
    .raddr(rd_ptr_r),
    .rdata(mem_rdata)
  );
  // Head byte is shown ahead so the state machine sees it before popping
  assign core_rdata = mem_rdata;

  // Next pointer values wrap at the active capacity, so a 255-byte
  // buffer never touches the upper part of the array
  assign wr_ptr_nxt = ((aw+1)'(wr_ptr_r) + 1'b1 >= capacity) ? '0 : wr_ptr_r + 1'b1;
  assign rd_ptr_nxt = ((aw+1)'(rd_ptr_r) + 1'b1 >= capacity) ? '0 : rd_ptr_r + 1'b1;

  // Write pointer; flush takes priority over a same-cycle write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
    end else if (do_wr) begin
      wr_ptr_r <= wr_ptr_nxt;
    end
  end

  // Read pointer; an empty buffer never advances it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr_r <= '0;
    end else if (flush) begin
      rd_ptr_r <= '0;
    end else if (do_rd) begin
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // Fill count; a write and a read in one cycle cancel out
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stored_byte_count_r <= '0;
    end else if (flush) begin
      stored_byte_count_r <= '0;
    end else if (do_wr && !do_rd) begin
      stored_byte_count_r <= stored_byte_count_r + 1'b1;
    end else if (do_rd && !do_wr) begin
      stored_byte_count_r <= stored_byte_count_r - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Size and extension bits; the flush bit of the same byte is not stored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      size_limit_select_r <= 1'b0;
      level_ext_r <= 1'b0;
    end else if (ctrl_wr) begin
      size_limit_select_r <= req.wdata[size_limit_bit];
      level_ext_r <= req.wdata[level_ext_bit];
    end
  end

  // Low byte of the shared threshold
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      water_level_low_r <= water_level_reset;
    end else if (req.wr && req.addr == water_level_low_off) begin
      water_level_low_r <= req.wdata;
    end
  end

  // Interrupt enables
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_enable_first_r <= int_enable_reset;
    end else if (req.wr && req.addr == int_enable_first_off) begin
      int_enable_first_r <= req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------
  // Alerts are levels; only their rising edges reach the status bits
  // Previous alert levels for rising-edge detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      almost_full_d_r <= 1'b0;
      almost_empty_d_r <= 1'b1;
    end else begin
      almost_full_d_r <= almost_full_flag;
      almost_empty_d_r <= almost_empty_flag;
    end
  end

  // Rising edges of the two alert levels
  assign af_rise = almost_full_flag && !almost_full_d_r;
  assign ae_rise = almost_empty_flag && !almost_empty_d_r;

  // Overflow is sticky; write 1 clears, a new event in the same cycle wins
  // so that no dropped byte goes unreported
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      overflow_flag_r <= 1'b0;
    end else if (any_wr && full && !flush) begin
      overflow_flag_r <= 1'b1;
    end else if (status_wr && req.wdata[err_src_bit]) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // Almost-full status, set on the rise only so a level that stays high
  // does not raise the pin again after software cleared it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      almost_full_int_r <= 1'b0;
    end else if (af_rise) begin
      almost_full_int_r <= 1'b1;
    end else if (status_wr && req.wdata[af_int_bit]) begin
      almost_full_int_r <= 1'b0;
    end
  end

  // Almost-empty status, same scheme
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      almost_empty_int_r <= 1'b0;
    end else if (ae_rise) begin
      almost_empty_int_r <= 1'b1;
    end else if (status_wr && req.wdata[ae_int_bit]) begin
      almost_empty_int_r <= 1'b0;
    end
  end

  // Interrupt pin gated by the enables; overflow shares the pin
  // only when its own enable bit is set
  assign irq = (almost_empty_int_r & int_enable_first_r[ae_int_bit])
             | (almost_full_int_r & int_enable_first_r[af_int_bit])
             | (overflow_flag_r & int_enable_first_r[err_src_bit]);

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ctrl_off: begin
          rdata_r <= 8'h00;
          rdata_r[size_limit_bit] <= size_limit_select_r;
          rdata_r[almost_full_bit] <= almost_full_flag;
          rdata_r[almost_empty_bit] <= almost_empty_flag;
          rdata_r[level_ext_bit] <= level_ext_r;
          // Upper count bits only meaningful in full-size mode; both are
          // needed so that a completely full buffer does not read as zero
          rdata_r[count_hi_bit] <= stored_byte_count_r[aw-1] & ~size_limit_select_r;
          rdata_r[count_hi_bit + 1] <= stored_byte_count_r[aw] & ~size_limit_select_r;
        end
        water_level_low_off: rdata_r <= water_level_low_r;
        count_low_off: rdata_r <= stored_byte_count_r[7:0];
        data_off: rdata_r <= empty ? 8'h00 : mem_rdata;
        int_status_first_off: begin
          rdata_r <= 8'h00;
          rdata_r[err_src_bit] <= overflow_flag_r;
          rdata_r[ae_int_bit] <= almost_empty_int_r;
          rdata_r[af_int_bit] <= almost_full_int_r;
        end
        int_enable_first_off: rdata_r <= int_enable_first_r;
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  // Read data stand one cycle and fall back to zero, so a stale value
  // is never mistaken for a fresh answer
  assign rdata = rdata_r;
endmodule // fifo_level_watermark_control
`default_nettype wire

/* File: inc/buf_pkg.sv */
package buf_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ctrl_off = 8'h02; // buffer_control_reg
  localparam logic [7:0] water_level_low_off = 8'h03;
  localparam logic [7:0] data_off = 8'h05; // Buffer data port
  localparam logic [7:0] count_low_off = 8'h04; // stored_byte_count low byte
  localparam logic [7:0] int_status_first_off = 8'h06;
  localparam logic [7:0] int_enable_first_off = 8'h08;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int size_limit_bit = 7;
  localparam int almost_full_bit = 6;
  localparam int almost_empty_bit = 5;
  localparam int flush_bit = 4;
  localparam int level_ext_bit = 2;
  localparam int count_hi_bit = 0;
  localparam int err_src_bit = 1;
  localparam int ae_int_bit = 2;
  localparam int af_int_bit = 3;
  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int full_depth = 512;
  localparam int small_depth = 255;
  localparam logic [7:0] water_level_reset = 8'h08;
  localparam logic [7:0] int_enable_reset = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
endpackage

/* File: verilog/buf_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module buf_mem
  import buf_pkg::*;
#(
  parameter int width = 8,
  parameter int depth = 512,
  parameter int aw = 9
) (
  // Clock
  input wire logic mclk,
  // Write side
  input wire logic we,
  input wire logic [aw-1:0] waddr,
  input wire logic [width-1:0] wdata,
  // Read side
  input wire logic [aw-1:0] raddr,
  output logic [width-1:0] rdata
);
  logic [width-1:0] mem [depth];

  // Storage; no reset so it maps to a RAM macro
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule // buf_mem
`default_nettype wire

/* File: test/fifo_level_watermark_control_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module fifo_level_watermark_control_assertions
  import buf_pkg::*;
#(parameter int depth = full_depth) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire reg_req_type req,
  input wire logic [7:0] rdata,
  // Core side
  input wire logic core_wr,
  input wire logic [7:0] core_wdata,
  input wire logic core_rd,
  input wire logic [7:0] core_rdata,
  input wire logic core_empty,
  input wire logic core_full,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [9:0] cnt_r, cap, thr;
  logic sz_r, ext_r, wr, rd, fl, af, ae, hi;
  logic [7:0] wl_r;
  // Shadow level rebuilt from port traffic only
  assign wr = core_wr | (req.wr && req.addr == data_off);
  assign rd = core_rd | (req.rd && req.addr == data_off);
  assign fl = req.wr && req.addr == ctrl_off && req.wdata[flush_bit];
  assign cap = sz_r ? 10'(small_depth) : 10'(depth);
  assign thr = sz_r ? {2'b0, wl_r} : {1'b0, ext_r, wl_r};
  assign af = (cap - cnt_r) <= thr;
  assign ae = cnt_r <= thr;
  assign hi = !sz_r && cnt_r[8];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) cnt_r <= '0;
    else if (fl) cnt_r <= '0;
    else cnt_r <= cnt_r + 10'(wr && cnt_r != cap) - 10'(rd && cnt_r != 0);
  end
  // Size, extension and threshold copies
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {sz_r, ext_r} <= 2'b00;
      wl_r <= water_level_reset;
    end else if (req.wr) begin
      if (req.addr == ctrl_off) {sz_r, ext_r} <= {req.wdata[size_limit_bit], req.wdata[level_ext_bit]};
      if (req.addr == water_level_low_off) wl_r <= req.wdata;
    end
  end
  sequence s_flush;
    req.wr && req.addr == ctrl_off && req.wdata[flush_bit];
  endsequence
  sequence s_rd(a);
    req.rd && req.addr == a;
  endsequence
  a_flush_empties: assert property (s_flush |=> core_empty && !core_full) else $error("flush kept data");
  a_empty_level: assert property (core_empty == (cnt_r == 0)) else $error("empty wrong");
  a_full_level: assert property (core_full == (cnt_r == cap)) else $error("full wrong");
  a_count_low: assert property (s_rd(count_low_off) |=> rdata == $past(cnt_r[7:0])) else $error("count");
  a_count_high: assert property (s_rd(ctrl_off) |=> rdata[count_hi_bit] == $past(hi)) else $error("hi");
  a_full_alert: assert property (s_rd(ctrl_off) |=> rdata[almost_full_bit] == $past(af)) else $error("af");
  a_empty_alert: assert property (s_rd(ctrl_off) |=> rdata[almost_empty_bit] == $past(ae)) else $error("ae");
  a_level_read: assert property (s_rd(water_level_low_off) |=> rdata == $past(wl_r)) else $error("lvl");
  a_full_drop: assert property (wr && !rd && !fl && core_full |=> core_full) else $error("drop");
  a_empty_read: assert property (rd && !wr && !fl && core_empty |=> core_empty) else $error("pop");
endmodule // fifo_level_watermark_control_assertions
`default_nettype wire

/* File: test/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model
  import buf_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register port toward the block
  output reg_req_type req,
  input wire logic [7:0] rdata
);
  // Bus idles until a cycle is asked for
  initial req = '0;
  // One-cycle strobe, then an idle edge so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req <= '0;
    #1 d = rdata;
  endtask
endmodule // host_model
`default_nettype wire

/* File: test/test_fifo_level_watermark_control.sv */
`timescale 1ns/1ns
`default_nettype none
module test_fifo_level_watermark_control;
  import buf_pkg::*;
  logic mclk, rstn = 0, core_wr = 0, core_rd = 0, irq, core_empty, core_full;
  logic [7:0] core_wdata = 8'ha5, core_rdata, rdata, v;
  reg_req_type req;
  int miscompares = 0, checked = 0;
  fifo_level_watermark_control #(.depth(full_depth), .aw(9)) u_fifo_level_watermark_control (.mclk(mclk),
    .rstn(rstn), .req(req), .rdata(rdata), .core_wr(core_wr), .core_wdata(core_wdata), .core_rd(core_rd),
    .core_rdata(core_rdata), .core_empty(core_empty), .core_full(core_full), .irq(irq));
  host_model u_host_model (.mclk(mclk), .req(req), .rdata(rdata));
  // Free-running 20 MHz clock
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    u_host_model.rd(a, v);
    chk(what, v, exp);
  endtask
  // Back-to-back core pushes or pops, n of them
  task automatic move(input logic push, input int n);
    @(posedge mclk);
    if (push) core_wr <= 1; else core_rd <= 1;
    repeat (n) @(posedge mclk);
    core_wr <= 0;
    core_rd <= 0;
  endtask
  // Status flop lands one edge after the alert moves
  task automatic irqchk(input logic exp);
    repeat (2) @(posedge mclk);
    #1 chk("irq", {7'h0, irq}, {7'h0, exp});
  endtask
  task automatic t_reset;
    rchk("level", water_level_low_off, water_level_reset);
    rchk("enable", int_enable_first_off, int_enable_reset);
    rchk("unmapped", 8'h7f, 8'h00);
  endtask
  task automatic t_fill;
    move(1, 511);
    rchk("ctrl", ctrl_off, 8'h41);
    rchk("count", count_low_off, 8'hff);
    move(1, 1);
    rchk("ctrl", ctrl_off, 8'h42);
    u_host_model.wr(data_off, 8'h5a);
    chk("full", {7'h0, core_full}, 8'h01);
    rchk("status", int_status_first_off, 8'h0a);
    irqchk(0);
  endtask
  task automatic t_flush;
    u_host_model.wr(ctrl_off, 8'h10);
    chk("empty", {7'h0, core_empty}, 8'h01);
    rchk("ctrl", ctrl_off, 8'h20);
    rchk("pop", data_off, 8'h00);
    u_host_model.wr(data_off, 8'h3c);
    chk("head", core_rdata, 8'h3c);
    rchk("pop", data_off, 8'h3c);
    rchk("count", count_low_off, 8'h00);
  endtask
  task automatic t_irq;
    u_host_model.wr(int_status_first_off, 8'hff);
    u_host_model.wr(int_enable_first_off, 8'h0c);
    move(1, 9);
    irqchk(0);
    move(0, 1);
    irqchk(1);
    u_host_model.wr(int_status_first_off, 8'h04);
    irqchk(0);
  endtask
  // Extension bit lifts the threshold to 256
  task automatic t_ext;
    u_host_model.wr(water_level_low_off, 8'h00);
    u_host_model.wr(ctrl_off, 8'h04);
    rchk("ctrl", ctrl_off, 8'h24);
    u_host_model.wr(int_status_first_off, 8'hff);
    irqchk(0);
    move(1, 248);
    irqchk(1);
    rchk("ctrl", ctrl_off, 8'h65);
    rchk("status", int_status_first_off, 8'h08);
    move(1, 1);
    rchk("ctrl", ctrl_off, 8'h45);
  endtask
  task automatic t_small;
    u_host_model.wr(ctrl_off, 8'h90);
    move(1, 254);
    rchk("ctrl", ctrl_off, 8'h80);
    rchk("count", count_low_off, 8'hfe);
    move(1, 1);
    rchk("ctrl", ctrl_off, 8'hc0);
    chk("full", {7'h0, core_full}, 8'h01);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1;
    t_reset;
    t_fill;
    t_flush;
    t_irq;
    t_ext;
    t_small;
    give_verdict;
  end
  // Whole run needs about 1100 cycles
  initial begin
    #(50 * 20000);
    miscompares++;
    give_verdict;
  end
endmodule // test_fifo_level_watermark_control
bind fifo_level_watermark_control fifo_level_watermark_control_assertions #(.depth(depth)) u_chk (.mclk(mclk),
  .rstn(rstn), .req(req), .rdata(rdata), .core_wr(core_wr), .core_wdata(core_wdata), .core_rd(core_rd),
  .core_rdata(core_rdata), .core_empty(core_empty), .core_full(core_full), .irq(irq));
`default_nettype wire
